// ---- hw/cdc_pkg.sv ----
// Function
// - Clock fail detection sets a software-clearable flag
// - Secondary oscillator runs while its enable set
// - Switch request clears when switch completes
// - Control registers reset only on power-on
// - Interrupt clears ratio apply when recovery set
// - Processor ratio divides by two to code
// - Ratio apply off forces one to one
// - Fast RC postscaler divides, code seven 256
// - VCO output divider 2,4,8; code two reserved
// - PLL prescaler divides by code plus two
// - Feedback multiplier is code plus two
// - Fast RC trim is signed step offset
// - Auxiliary PLL runs when on, reports lock
// - Aux divider source: main PLL or others
// - Aux output divider, code zero gives 256
// - Aux reference: fast RC, primary or none
// - Reference output on when enabled, sleep rule
// - Reference source: crystal or system clock
// - Shared three-bit clock source code
package cdc_pkg;
  localparam logic [2:0] CDC_A_OSC  = 3'h0;
  localparam logic [2:0] CDC_A_DIV  = 3'h1;
  localparam logic [2:0] CDC_A_FBD  = 3'h2;
  localparam logic [2:0] CDC_A_TUN  = 3'h3;
  localparam logic [2:0] CDC_A_AUX  = 3'h4;
  localparam logic [2:0] CDC_A_REF  = 3'h5;
  localparam logic [2:0] CDC_A_KEY  = 3'h6;
  localparam logic [15:0] CDC_KEY1  = 16'h0046;
  localparam logic [15:0] CDC_KEY2  = 16'h0057;
  localparam logic [15:0] CDC_DIV_RST = 16'h3040;
  localparam logic [8:0]  CDC_FBD_RST = 9'h030;
  localparam logic [15:0] CDC_AUX_RST = 16'h2000;
  localparam logic [1:0]  CDC_POST_RSV = 2'h2;
  localparam int CDC_REF_DW = 16;

  typedef enum logic [2:0] {
    CDC_SRC_FRC     = 3'b000,
    CDC_SRC_FRCPLL  = 3'b001,
    CDC_SRC_PRI     = 3'b010,
    CDC_SRC_PRIPLL  = 3'b011,
    CDC_SRC_SEC     = 3'b100,
    CDC_SRC_LPRC    = 3'b101,
    CDC_SRC_FRC16   = 3'b110,
    CDC_SRC_FRCN    = 3'b111
  } cdc_src_t;

  // Settings driven out to the clock sources and PLLs
  typedef struct packed {
    logic [2:0] periph_ratio_select;
    logic       ratio_apply;
    logic [2:0] fast_rc_postdiv;
    logic [1:0] vco_out_div;
    logic [4:0] phase_det_in_div;
    logic [8:0] feedback_mult;
    logic [5:0] fast_rc_trim;
    logic       aux_pll_on;
    logic       aux_div_src_select;
    logic [2:0] aux_out_div;
    logic       aux_ref_primary;
    logic       aux_ref_fast_rc;
  } cdc_cfg_t;
endpackage

// ---- hw/cdc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdc_sync (
  // Clocking
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // Data
  input  wire logic d,
  output logic      q
);
  logic s1_q;
  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      q    <= 1'b0;
    end else if (ce) begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule
`default_nettype wire

// ---- hw/cdc_refdiv.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdc_refdiv #(
  parameter int DW = 16
) (
  // Clocking
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic [3:0] code,
  input  wire logic       src,
  // Output
  output logic            clk_out
);
  logic [DW-1:0] cnt_q;
  logic          src_q;
  initial begin
    if (DW < 16) $error("cdc_refdiv: DW must be at least 16");
  end
  // Counts source edges; bit code-1 of the count is the divided clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      src_q   <= 1'b0;
      clk_out <= 1'b0;
    end else if (ce) begin
      src_q <= src;
      if (!run) begin
        cnt_q   <= '0;
        clk_out <= 1'b0;
      end else if (code == 4'h0) begin
        clk_out <= src;
      end else if (src && !src_q) begin
        cnt_q   <= cnt_q + 1'b1;
        clk_out <= cnt_q[code - 4'h1] ^ (&(cnt_q & ((16'h1 << (code - 4'h1)) - 16'h1)));
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/cdc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdc_ctrl (
  // Clock and resets
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Register port
  input  wire logic [2:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [15:0]          reg_rdata,
  // Power-on strap and events
  input  wire logic [2:0]           strap_src,
  input  wire logic                 irq_event,
  input  wire logic                 sleep_mode,
  // Oscillator side status, asynchronous
  input  wire logic                 clock_fail_monitor,
  input  wire logic                 switch_done,
  input  wire logic                 aux_pll_lock_raw,
  input  wire logic                 crystal_clk,
  // Oscillator side controls
  output logic                      secondary_osc_run,
  output logic                      switch_go,
  output logic      [2:0]           switch_target,
  output cdc_pkg::cdc_cfg_t         cfg,
  output logic                      refout_pin,
  output logic                      refout_pin_oe
);
  // Oscillator control fields
  logic [2:0] current_source_status_q;
  logic [2:0] next_source_select_q;
  logic       clock_fail_flag_q;
  logic       secondary_osc_enable_q;
  logic       switch_request_q;
  // Unlock state: 0 idle, 1 first key seen, 2 unlocked
  logic [1:0] unlock_q;
  // Clock divisor fields
  logic       recover_on_irq_q;
  logic [2:0] periph_ratio_select_q;
  logic       ratio_apply_q;
  logic [2:0] fast_rc_postdiv_q;
  logic [1:0] vco_out_div_q;
  logic [4:0] phase_det_in_div_q;
  logic [8:0] feedback_mult_q;
  logic [5:0] fast_rc_trim_q;
  // Auxiliary clock fields
  logic       aux_pll_on_q;
  logic       aux_div_src_select_q;
  logic [2:0] aux_out_div_q;
  logic       aux_ref_primary_q;
  logic       aux_ref_fast_rc_q;
  // Reference output fields
  logic       refout_on_q;
  logic       refout_in_sleep_q;
  logic       refout_src_select_q;
  logic [3:0] refout_div_q;
  // Strap capture after reset release
  logic       strap_done_q;
  // Synchronised inputs
  logic       fail_s;
  logic       done_s;
  logic       lock_s;
  logic       xtal_s;
  logic       done_prev_q;
  logic       done_rise;
  logic       osc_wr;
  logic       ref_run;

  cdc_sync u_fail (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d(clock_fail_monitor), .q(fail_s));
  cdc_sync u_done (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d(switch_done), .q(done_s));
  cdc_sync u_lock (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d(aux_pll_lock_raw), .q(lock_s));
  cdc_sync u_xtal (.clk_sys(clk_sys), .rst(rst), .ce(ce), .d(crystal_clk), .q(xtal_s));

  assign done_rise = done_s && !done_prev_q;
  assign osc_wr    = reg_wr && reg_addr == cdc_pkg::CDC_A_OSC && unlock_q == 2'h2;

  // Unlock key sequence gating oscillator control writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unlock_q <= 2'h0;
    end else if (ce && reg_wr) begin
      if (reg_addr == cdc_pkg::CDC_A_KEY) begin
        if (reg_wdata == cdc_pkg::CDC_KEY1) unlock_q <= 2'h1;
        else if (reg_wdata == cdc_pkg::CDC_KEY2 && unlock_q == 2'h1) unlock_q <= 2'h2;
        else unlock_q <= 2'h0;
      end else begin
        unlock_q <= 2'h0;
      end
    end
  end

  // Oscillator control; reset is power-on only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      current_source_status_q <= 3'h0;
      next_source_select_q    <= 3'h0;
      clock_fail_flag_q       <= 1'b0;
      secondary_osc_enable_q  <= 1'b0;
      switch_request_q        <= 1'b0;
      strap_done_q            <= 1'b0;
      done_prev_q             <= 1'b0;
    end else if (ce) begin
      done_prev_q <= done_s;
      if (!strap_done_q) begin
        strap_done_q            <= 1'b1;
        current_source_status_q <= strap_src;
        next_source_select_q    <= strap_src;
      end
      if (osc_wr) begin
        next_source_select_q   <= reg_wdata[10:8];
        secondary_osc_enable_q <= reg_wdata[1];
        if (reg_wdata[0]) switch_request_q <= 1'b1;
        if (!reg_wdata[3]) clock_fail_flag_q <= 1'b0;
      end
      if (fail_s) clock_fail_flag_q <= 1'b1;
      if (done_rise && switch_request_q) begin
        switch_request_q        <= 1'b0;
        current_source_status_q <= next_source_select_q;
      end
    end
  end

  // Clock divisor, feedback and trim registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      recover_on_irq_q      <= cdc_pkg::CDC_DIV_RST[15];
      periph_ratio_select_q <= cdc_pkg::CDC_DIV_RST[14:12];
      ratio_apply_q         <= cdc_pkg::CDC_DIV_RST[11];
      fast_rc_postdiv_q     <= cdc_pkg::CDC_DIV_RST[10:8];
      vco_out_div_q         <= cdc_pkg::CDC_DIV_RST[7:6];
      phase_det_in_div_q    <= cdc_pkg::CDC_DIV_RST[4:0];
      feedback_mult_q       <= cdc_pkg::CDC_FBD_RST;
      fast_rc_trim_q        <= 6'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == cdc_pkg::CDC_A_DIV) begin
        recover_on_irq_q      <= reg_wdata[15];
        periph_ratio_select_q <= reg_wdata[14:12];
        ratio_apply_q         <= reg_wdata[11];
        fast_rc_postdiv_q     <= reg_wdata[10:8];
        if (reg_wdata[7:6] != cdc_pkg::CDC_POST_RSV) vco_out_div_q <= reg_wdata[7:6];
        phase_det_in_div_q    <= reg_wdata[4:0];
      end
      if (irq_event && recover_on_irq_q) ratio_apply_q <= 1'b0;
      if (reg_wr && reg_addr == cdc_pkg::CDC_A_FBD) feedback_mult_q <= reg_wdata[8:0];
      if (reg_wr && reg_addr == cdc_pkg::CDC_A_TUN) fast_rc_trim_q <= reg_wdata[5:0];
    end
  end

  // Auxiliary and reference output control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aux_pll_on_q         <= cdc_pkg::CDC_AUX_RST[15];
      aux_div_src_select_q <= cdc_pkg::CDC_AUX_RST[13];
      aux_out_div_q        <= cdc_pkg::CDC_AUX_RST[10:8];
      aux_ref_primary_q    <= cdc_pkg::CDC_AUX_RST[7];
      aux_ref_fast_rc_q    <= cdc_pkg::CDC_AUX_RST[6];
      refout_on_q          <= 1'b0;
      refout_in_sleep_q    <= 1'b0;
      refout_src_select_q  <= 1'b0;
      refout_div_q         <= 4'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == cdc_pkg::CDC_A_AUX) begin
        aux_pll_on_q         <= reg_wdata[15];
        aux_div_src_select_q <= reg_wdata[13];
        aux_out_div_q        <= reg_wdata[10:8];
        aux_ref_primary_q    <= reg_wdata[7];
        aux_ref_fast_rc_q    <= reg_wdata[6];
      end
      if (reg_wr && reg_addr == cdc_pkg::CDC_A_REF) begin
        refout_on_q         <= reg_wdata[15];
        refout_in_sleep_q   <= reg_wdata[13];
        refout_src_select_q <= reg_wdata[12];
        refout_div_q        <= reg_wdata[11:8];
      end
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0;
    end else if (ce) begin
      reg_rdata <= 16'h0;
      if (reg_rd) begin
        unique case (reg_addr)
          cdc_pkg::CDC_A_OSC: reg_rdata <= {1'b0, current_source_status_q, 1'b0,
                                            next_source_select_q, 4'h0, clock_fail_flag_q,
                                            1'b0, secondary_osc_enable_q, switch_request_q};
          cdc_pkg::CDC_A_DIV: reg_rdata <= {recover_on_irq_q, periph_ratio_select_q,
                                            ratio_apply_q, fast_rc_postdiv_q, vco_out_div_q,
                                            1'b0, phase_det_in_div_q};
          cdc_pkg::CDC_A_FBD: reg_rdata <= {7'h0, feedback_mult_q};
          cdc_pkg::CDC_A_TUN: reg_rdata <= {10'h0, fast_rc_trim_q};
          cdc_pkg::CDC_A_AUX: reg_rdata <= {aux_pll_on_q, aux_pll_on_q && lock_s,
                                            aux_div_src_select_q, 2'h0, aux_out_div_q,
                                            aux_ref_primary_q, aux_ref_fast_rc_q, 6'h0};
          cdc_pkg::CDC_A_REF: reg_rdata <= {refout_on_q, 1'b0, refout_in_sleep_q,
                                            refout_src_select_q, refout_div_q, 8'h0};
          default:            reg_rdata <= 16'h0;
        endcase
      end
    end
  end

  // Settings to the clock tree
  always_comb begin
    cfg.periph_ratio_select = periph_ratio_select_q;
    cfg.ratio_apply         = ratio_apply_q;
    cfg.fast_rc_postdiv     = fast_rc_postdiv_q;
    cfg.vco_out_div         = vco_out_div_q;
    cfg.phase_det_in_div    = phase_det_in_div_q;
    cfg.feedback_mult       = feedback_mult_q;
    cfg.fast_rc_trim        = fast_rc_trim_q;
    cfg.aux_pll_on          = aux_pll_on_q;
    cfg.aux_div_src_select  = aux_div_src_select_q;
    cfg.aux_out_div         = aux_out_div_q;
    cfg.aux_ref_primary     = aux_ref_primary_q;
    cfg.aux_ref_fast_rc     = aux_ref_fast_rc_q;
  end

  assign secondary_osc_run = secondary_osc_enable_q;
  assign switch_go         = switch_request_q;
  assign switch_target     = next_source_select_q;
  assign ref_run           = refout_on_q && (!sleep_mode || refout_in_sleep_q);
  assign refout_pin_oe     = refout_on_q;

  // Reference divider; source is crystal or system clock
  cdc_refdiv #(.DW(cdc_pkg::CDC_REF_DW)) u_ref (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (ref_run),
    .code    (refout_div_q),
    .src     (refout_src_select_q ? xtal_s : 1'b1),
    .clk_out (refout_pin)
  );

  // Checks
  flag_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && fail_s |=> clock_fail_flag_q) else $error("fail flag not set");
  sec_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && osc_wr |=> secondary_osc_run == $past(reg_wdata[1]))
    else $error("sec osc mismatch");
  switch_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && done_rise && switch_request_q && !osc_wr |=> !switch_request_q)
    else $error("switch request not cleared");
  irq_recover_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && irq_event && recover_on_irq_q |=> !ratio_apply_q)
    else $error("ratio apply not cleared");
  irq_noeffect_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && irq_event && !recover_on_irq_q && !reg_wr |=> $stable(ratio_apply_q))
    else $error("ratio apply changed");
  post_rsv_a: assert property (@(posedge clk_sys) disable iff (rst)
    vco_out_div_q != cdc_pkg::CDC_POST_RSV) else $error("reserved postscaler");
  lock_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && reg_addr == cdc_pkg::CDC_A_AUX && !aux_pll_on_q |=> !reg_rdata[14])
    else $error("lock shown while off");
  ref_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !refout_on_q ##1 !refout_on_q |-> !refout_pin) else $error("ref out runs");
  lock_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_wr && reg_addr == cdc_pkg::CDC_A_OSC && unlock_q != 2'h2
    |=> $stable(next_source_select_q) || $past(!strap_done_q))
    else $error("locked write taken");
endmodule
`default_nettype wire

// ---- testbench/cdc_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Oscillator side: switch handshake, aux lock, crystal, fail monitor
module cdc_osc_model (
  // Clocking
  input  wire logic clk_sys,
  input  wire logic rst,
  // From the block and the scenario
  input  wire logic switch_go,
  input  wire logic aux_pll_on,
  input  wire logic fail_cmd,
  // To the block
  output logic      switch_done,
  output logic      clock_fail_monitor,
  output logic      aux_pll_lock_raw,
  output logic      crystal_clk
);
  int unsigned sw_cnt;
  int unsigned lk_cnt;

  // Crystal runs free at 12.5 MHz, unrelated to the system clock
  initial begin
    crystal_clk = 1'b0;
    forever #40 crystal_clk = ~crystal_clk;
  end

  // Fail monitor follows the scenario's fault command
  assign clock_fail_monitor = fail_cmd;

  // Switch completes 20 cycles after the request, held until it drops
  always @(posedge clk_sys or posedge rst) begin
    if (rst || !switch_go) begin
      sw_cnt <= 0;
      switch_done <= 1'b0;
    end else if (sw_cnt == 20) begin
      switch_done <= 1'b1;
    end else begin
      sw_cnt <= sw_cnt + 1;
    end
  end

  // Aux PLL locks 30 cycles after it is turned on, loses lock when off
  always @(posedge clk_sys or posedge rst) begin
    if (rst || !aux_pll_on) begin
      lk_cnt <= 0;
      aux_pll_lock_raw <= 1'b0;
    end else if (lk_cnt == 30) begin
      aux_pll_lock_raw <= 1'b1;
    end else begin
      lk_cnt <= lk_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_cdc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_cdc_ctrl;
  logic              clk_sys, rst, reg_wr, reg_rd, irq_event, sleep_mode, fail_cmd;
  logic [2:0]        reg_addr, strap_src, switch_target;
  logic [15:0]       reg_wdata, reg_rdata, rv;
  logic              secondary_osc_run, switch_go, refout_pin, refout_pin_oe;
  logic              clock_fail_monitor, switch_done, aux_pll_lock_raw, crystal_clk;
  cdc_pkg::cdc_cfg_t cfg;
  int                miscompares, check_count, n;

  cdc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_src(strap_src), .irq_event(irq_event), .sleep_mode(sleep_mode),
    .clock_fail_monitor(clock_fail_monitor), .switch_done(switch_done),
    .aux_pll_lock_raw(aux_pll_lock_raw), .crystal_clk(crystal_clk),
    .secondary_osc_run(secondary_osc_run), .switch_go(switch_go),
    .switch_target(switch_target), .cfg(cfg), .refout_pin(refout_pin),
    .refout_pin_oe(refout_pin_oe));
  cdc_osc_model osc (.clk_sys(clk_sys), .rst(rst), .switch_go(switch_go),
    .aux_pll_on(cfg.aux_pll_on), .fail_cmd(fail_cmd), .switch_done(switch_done),
    .clock_fail_monitor(clock_fail_monitor), .aux_pll_lock_raw(aux_pll_lock_raw),
    .crystal_clk(crystal_clk));

  // System clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Two key writes directly followed by the oscillator control write
  task automatic wr_unl(input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= cdc_pkg::CDC_A_KEY;
    reg_wdata <= cdc_pkg::CDC_KEY1;
    @(posedge clk_sys);
    reg_wdata <= cdc_pkg::CDC_KEY2;
    @(posedge clk_sys);
    reg_addr <= cdc_pkg::CDC_A_OSC;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rises(input int cyc, output int c);
    logic p;
    c = 0;
    p = refout_pin;
    repeat (cyc) begin
      @(posedge clk_sys);
      #1 if (refout_pin === 1'b1 && p === 1'b0) c++;
      p = refout_pin;
    end
  endtask

  // Power-on values of every register, strap loaded as source
  task automatic t_reset;
    rd(3'h0, rv); chk("osc_rst", rv, 16'h6600);
    rd(3'h1, rv); chk("div_rst", rv, 16'h3040);
    rd(3'h2, rv); chk("fbd_rst", rv, 16'h0030);
    rd(3'h3, rv); chk("tun_rst", rv, 16'h0000);
    rd(3'h4, rv); chk("aux_rst", rv, 16'h2000);
    rd(3'h5, rv); chk("ref_rst", rv, 16'h0000);
    rd(3'h7, rv); chk("unmapped", rv, 16'h0000);
  endtask

  // Locked write refused, unlocked switch request completes
  task automatic t_switch;
    wr(3'h0, 16'h0503);
    rd(3'h0, rv); chk("osc_locked", rv, 16'h6600);
    wr_unl(16'h0201);
    @(posedge clk_sys);
    #1 chk("go", 16'(switch_go), 16'h0001);
    chk("target", 16'(switch_target), 16'h0002);
    n = 0;
    while (switch_go !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    rd(3'h0, rv); chk("osc_switched", rv, 16'h2200);
  endtask

  // Clock fail flag set, cleared; secondary oscillator enable
  task automatic t_fail;
    fail_cmd <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(3'h0, rv); chk("cf_set", rv & 16'h0008, 16'h0008);
    fail_cmd <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr_unl(16'h0202);
    rd(3'h0, rv); chk("cf_clr", rv, 16'h2202);
    chk("sec_run", 16'(secondary_osc_run), 16'h0001);
    wr_unl(16'h0200);
    #1 chk("sec_stop", 16'(secondary_osc_run), 16'h0000);
  endtask

  // Divisor fields, reserved postscaler code, interrupt recovery
  task automatic t_div;
    wr(3'h1, 16'hddcd);
    #1 chk("ratio", 16'(cfg.periph_ratio_select), 16'h0005);
    chk("apply", 16'(cfg.ratio_apply), 16'h0001);
    chk("frcdiv", 16'(cfg.fast_rc_postdiv), 16'h0005);
    chk("post", 16'(cfg.vco_out_div), 16'h0003);
    chk("pre", 16'(cfg.phase_det_in_div), 16'h000d);
    wr(3'h1, 16'hd88e);
    rd(3'h1, rv); chk("post_rsv", rv, 16'hd8ce);
    @(posedge clk_sys);
    irq_event <= 1'b1;
    @(posedge clk_sys);
    irq_event <= 1'b0;
    @(posedge clk_sys);
    #1 chk("irq_clr", 16'(cfg.ratio_apply), 16'h0000);
    wr(3'h1, 16'h7fc0);
    irq_event <= 1'b1;
    @(posedge clk_sys);
    irq_event <= 1'b0;
    @(posedge clk_sys);
    #1 chk("irq_keep", 16'(cfg.ratio_apply), 16'h0001);
    chk("ratio128", 16'(cfg.periph_ratio_select), 16'h0007);
  endtask

  // Feedback multiplier and trim, unimplemented bits read zero
  task automatic t_fbd;
    wr(3'h2, 16'hffff);
    rd(3'h2, rv); chk("fbd", rv, 16'h01ff);
    chk("mult", 16'(cfg.feedback_mult), 16'h01ff);
    wr(3'h3, 16'hffe0);
    rd(3'h3, rv); chk("tun", rv, 16'h0020);
    chk("trim", 16'(cfg.fast_rc_trim), 16'h0020);
  endtask

  // Aux PLL on, lock bit read-only and reported from the PLL
  task automatic t_aux;
    wr(3'h4, 16'hc7c0);
    rd(3'h4, rv); chk("aux_unlk", rv, 16'h87c0);
    chk("aux_cfg", 16'(cfg[11:0]), 16'h005f);
    repeat (50) @(posedge clk_sys);
    rd(3'h4, rv); chk("aux_lock", rv, 16'hc7c0);
    wr(3'h4, 16'h2040);
    repeat (6) @(posedge clk_sys);
    rd(3'h4, rv); chk("aux_off", rv, 16'h2040);
  endtask

  // Reference output: divider, sleep handling, source select
  task automatic t_ref;
    wr(3'h5, 16'h3100);
    wr(3'h5, 16'hb100);
    #1 chk("oe_on", 16'(refout_pin_oe), 16'h0001);
    sleep_mode <= 1'b1;
    rises(1600, n); chk("div2_sleep", 16'(n >= 98 && n <= 102), 16'h0001);
    wr(3'h5, 16'h0000);
    #1 chk("oe_off", 16'(refout_pin_oe), 16'h0000);
    wr(3'h5, 16'h9200);
    rises(200, n); chk("sleep_stop", 16'(n), 16'h0000);
    chk("sleep_low", 16'(refout_pin), 16'h0000);
    sleep_mode <= 1'b0;
    rises(1600, n); chk("div4", 16'(n >= 48 && n <= 52), 16'h0001);
    wr(3'h5, 16'h0000);
    wr(3'h5, 16'h8000);
    repeat (5) @(posedge clk_sys);
    #1 chk("sysclk_src", 16'(refout_pin), 16'h0001);
  endtask

  // Reset for three cycles, then the scenarios
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    irq_event = 1'b0;
    sleep_mode = 1'b0;
    fail_cmd = 1'b0;
    strap_src = cdc_pkg::CDC_SRC_FRC16;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_switch;
    t_fail;
    t_div;
    t_fbd;
    t_aux;
    t_ref;
    end_of_test;
  end

  // Watchdog well beyond the expected run of about 3600 cycles
  initial begin
    #500000;
    miscompares++;
    end_of_test;
  end
endmodule
`default_nettype wire
